// >>> design/dcp_top.v
// local serial control port with back-channel forwarding
`timescale 1ns/1ps
`include "dcp_regs.vh"
// Operation
// - target works with bus clocks up to 1 MHz, oversampled by the core clock
// - local register accesses never hold the clock line low
// - relayed transactions stretch the clock until the remote answer returns
// - proxy controller output enabled only by bit 5 of register 0x02
// - newer serializers get repeated start passed across the link
// - rate defaults from mode strap, overridable per port in 0x58
// - back channel runs at 50 Mbps or 2.5 Mbps
// - back channel carries GPIO state and advertises capabilities
// - strap sampled 1 ms after chip enable rises
// - strapped primary address stored in register 0x0
// - two alias addresses reach port 0 or port 1 registers directly
// - alias addresses also reach shared registers
// - port 0 alias at 0xF8, port 1 alias at 0xF9
// - strap codes 0..7 select 0x30,0x32,0x34,0x36,0x38,0x3A,0x3C,0x3D
// - forwarding only when bit 6 of 0x58 is set
module dcp_top #(
  parameter STRAP_WAIT_CYCLES = `DCP_STRAP_WAIT_NS / `DCP_CLK_NS
) (
  input wire CLK,
  input wire SRST,
  input wire CE,
  input wire CHIP_EN,
  input wire [2:0] ADDRESS_STRAP,
  input wire MODE_STRAP,
  input wire SCL_I,
  output reg SCL_O,
  output reg SCL_OE,
  input wire SDA_I,
  output reg SDA_O,
  output reg SDA_OE,
  input wire [1:0] SER_NEW,
  input wire [3:0] BC_GPIO_IN,
  output reg BC_REQ,
  output reg [1:0] BC_CMD,
  output reg [7:0] BC_WDATA,
  output reg BC_PORT,
  output reg BC_RESTART,
  input wire BC_DONE,
  input wire BC_NACK,
  input wire [7:0] BC_RDATA,
  output reg [2:0] BC_RATE0,
  output reg [2:0] BC_RATE1,
  output reg [3:0] BC_GPIO_OUT,
  output reg [7:0] BC_CAPS,
  output reg PROXY_EN
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RX = 3'h1;
  localparam [2:0] S_ACK = 3'h2;
  localparam [2:0] S_TX = 3'h3;
  localparam [2:0] S_TACK = 3'h4;
  localparam [2:0] S_STR = 3'h5;
  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_OFF = 2'h1;
  localparam [1:0] PH_DATA = 2'h2;
  localparam [1:0] ACC_PRI = 2'h0;
  localparam [1:0] ACC_P0 = 2'h1;
  localparam [1:0] ACC_P1 = 2'h2;
  // ------------------------------------------------------------
  // input synchronisers and strap
  // ------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  wire en_s;
  wire [3:0] strap_s;
  wire [6:0] strap_addr;
  wire strap_done;
  wire strap_take;
  dcp_sync #(.W(3), .INIT(3'h7)) u_sync_bus (
    .CLK(CLK), .SRST(SRST), .CE(CE), .D({SCL_I, SDA_I, CHIP_EN}), .Q({scl_s, sda_s, en_s})
  );
  dcp_sync #(.W(4), .INIT(4'h0)) u_sync_strap (
    .CLK(CLK), .SRST(SRST), .CE(CE), .D({MODE_STRAP, ADDRESS_STRAP}), .Q(strap_s)
  );
  dcp_strap #(.WAIT_CYCLES(STRAP_WAIT_CYCLES)) u_strap (
    .CLK(CLK), .SRST(SRST), .CE(CE), .EN(en_s), .CODE(strap_s[2:0]),
    .ADDR(strap_addr), .DONE(strap_done), .TAKE(strap_take)
  );
  wire rst = SRST | ~en_s;
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg scl_q_ff;
  reg sda_q_ff;
  reg [2:0] st_ff;
  reg [1:0] ph_ff;
  reg [3:0] bit_ff;
  reg [7:0] sh_ff;
  reg rw_ff;
  reg fwd_ff;
  reg rdpend_ff;
  reg hack_ff;
  reg [1:0] acc_ff;
  reg [7:0] ptr_ff;
  reg [7:0] id_ff;
  reg [7:0] gencfg_ff;
  reg [7:0] psel_ff;
  reg [7:0] alias0_ff;
  reg [7:0] alias1_ff;
  reg [7:0] gpo_ff;
  reg [7:0] lcfg_ff [0:1];
  reg [7:0] ralias_ff [0:1];
  reg [7:0] mem_ff [0:255];
  wire scl_rise = scl_s & ~scl_q_ff;
  wire scl_fall = ~scl_s & scl_q_ff;
  wire start_c = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  wire stop_c = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  wire [6:0] rx_addr = sh_ff[7:1];
  // ------------------------------------------------------------
  // port paging
  // ------------------------------------------------------------
  function rd_port;
    input [1:0] acc;
    input [7:0] psel;
    begin
      if (acc == ACC_P0) begin
        rd_port = 1'b0;
      end else if (acc == ACC_P1) begin
        rd_port = 1'b1;
      end else begin
        rd_port = psel[`DCP_PSEL_RD];
      end
    end
  endfunction
  function [1:0] wr_ports;
    input [1:0] acc;
    input [7:0] psel;
    begin
      if (acc == ACC_P0) begin
        wr_ports = 2'h1;
      end else if (acc == ACC_P1) begin
        wr_ports = 2'h2;
      end else begin
        wr_ports = {psel[`DCP_PSEL_WR1], psel[`DCP_PSEL_WR0]};
      end
    end
  endfunction
  wire port_sel = rd_port(acc_ff, psel_ff);
  wire [1:0] wport = wr_ports(acc_ff, psel_ff);
  wire addr_port = psel_ff[`DCP_PSEL_RD];
  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  reg [7:0] rdata;
  always @* begin
    case (ptr_ff)
      `DCP_REG_ID: rdata = id_ff;
      `DCP_REG_GENCFG: rdata = gencfg_ff;
      `DCP_REG_GPIO_OUT: rdata = gpo_ff;
      `DCP_REG_GPIO_IN: rdata = {4'h0, BC_GPIO_IN};
      `DCP_REG_PORTSEL: rdata = psel_ff;
      `DCP_REG_LINKCFG: rdata = lcfg_ff[port_sel];
      `DCP_REG_RALIAS: rdata = ralias_ff[port_sel];
      `DCP_REG_ALIAS0: rdata = alias0_ff;
      `DCP_REG_ALIAS1: rdata = alias1_ff;
      default: rdata = mem_ff[ptr_ff];
    endcase
  end
  // ------------------------------------------------------------
  // target engine and registers
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    if (rst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      st_ff <= S_IDLE;
      ph_ff <= PH_ADDR;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
      fwd_ff <= 1'b0;
      rdpend_ff <= 1'b0;
      hack_ff <= 1'b0;
      acc_ff <= ACC_PRI;
      ptr_ff <= 8'h00;
      id_ff <= {1'b0, `DCP_ADDR0};
      gencfg_ff <= 8'h00;
      psel_ff <= 8'h00;
      alias0_ff <= 8'h00;
      alias1_ff <= 8'h00;
      gpo_ff <= 8'h00;
      lcfg_ff[0] <= {5'h00, `DCP_RATE_SLOW};
      lcfg_ff[1] <= {5'h00, `DCP_RATE_SLOW};
      ralias_ff[0] <= 8'h00;
      ralias_ff[1] <= 8'h00;
      SCL_O <= 1'b0;
      SCL_OE <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE <= 1'b0;
      BC_REQ <= 1'b0;
      BC_CMD <= `DCP_CMD_START;
      BC_WDATA <= 8'h00;
      BC_PORT <= 1'b0;
      BC_RESTART <= 1'b0;
      BC_RATE0 <= `DCP_RATE_SLOW;
      BC_RATE1 <= `DCP_RATE_SLOW;
      BC_GPIO_OUT <= 4'h0;
      BC_CAPS <= `DCP_CAPS;
      PROXY_EN <= 1'b0;
    end else if (CE) begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      BC_REQ <= 1'b0;
      BC_RATE0 <= lcfg_ff[0][`DCP_RATE_MSB:`DCP_RATE_LSB];
      BC_RATE1 <= lcfg_ff[1][`DCP_RATE_MSB:`DCP_RATE_LSB];
      BC_GPIO_OUT <= gpo_ff[3:0];
      BC_CAPS <= `DCP_CAPS;
      PROXY_EN <= gencfg_ff[`DCP_PROXY_BIT];
      if (strap_take) begin
        id_ff <= {1'b0, strap_addr};
        lcfg_ff[0][`DCP_RATE_MSB:`DCP_RATE_LSB] <= strap_s[3] ? `DCP_RATE_FAST : `DCP_RATE_SLOW;
        lcfg_ff[1][`DCP_RATE_MSB:`DCP_RATE_LSB] <= strap_s[3] ? `DCP_RATE_FAST : `DCP_RATE_SLOW;
      end
      if (!strap_done) begin
        st_ff <= S_IDLE;
      end else if (stop_c) begin
        if (fwd_ff) begin
          BC_REQ <= 1'b1;
          BC_CMD <= `DCP_CMD_STOP;
        end
        fwd_ff <= 1'b0;
        st_ff <= S_IDLE;
        SDA_OE <= 1'b0;
        SCL_OE <= 1'b0;
      end else if (start_c) begin
        BC_RESTART <= fwd_ff & SER_NEW[BC_PORT];
        st_ff <= S_RX;
        ph_ff <= PH_ADDR;
        bit_ff <= 4'h0;
        SDA_OE <= 1'b0;
      end else begin
        case (st_ff)
          S_IDLE: begin
            SDA_OE <= 1'b0;
          end
          S_RX: begin
            if (scl_rise && bit_ff != `DCP_BYTE_BITS) begin
              sh_ff <= {sh_ff[6:0], sda_s};
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall && bit_ff == `DCP_BYTE_BITS) begin
              bit_ff <= 4'h0;
              if (ph_ff == PH_ADDR) begin
                rw_ff <= sh_ff[0];
                rdpend_ff <= 1'b0;
                if (rx_addr == id_ff[6:0] || (alias0_ff[6:0] != 7'h0 && rx_addr == alias0_ff[6:0])
                    || (alias1_ff[6:0] != 7'h0 && rx_addr == alias1_ff[6:0])) begin
                  fwd_ff <= 1'b0;
                  acc_ff <= (rx_addr == id_ff[6:0]) ? ACC_PRI :
                            (rx_addr == alias0_ff[6:0]) ? ACC_P0 : ACC_P1;
                  ph_ff <= PH_OFF;
                  SDA_OE <= 1'b1;
                  st_ff <= S_ACK;
                end else if (lcfg_ff[addr_port][`DCP_FWD_BIT] && ralias_ff[addr_port][6:0] != 7'h0
                             && rx_addr == ralias_ff[addr_port][6:0]) begin
                  fwd_ff <= 1'b1;
                  ph_ff <= PH_DATA;
                  BC_REQ <= 1'b1;
                  BC_CMD <= `DCP_CMD_START;
                  BC_WDATA <= sh_ff;
                  BC_PORT <= addr_port;
                  SCL_OE <= 1'b1;
                  st_ff <= S_STR;
                end else begin
                  st_ff <= S_IDLE;
                end
              end else if (ph_ff == PH_OFF) begin
                ptr_ff <= sh_ff;
                ph_ff <= PH_DATA;
                SDA_OE <= 1'b1;
                st_ff <= S_ACK;
              end else if (fwd_ff) begin
                BC_REQ <= 1'b1;
                BC_CMD <= `DCP_CMD_WRITE;
                BC_WDATA <= sh_ff;
                SCL_OE <= 1'b1;
                st_ff <= S_STR;
              end else begin
                case (ptr_ff)
                  `DCP_REG_ID: id_ff <= sh_ff;
                  `DCP_REG_GENCFG: gencfg_ff <= sh_ff;
                  `DCP_REG_GPIO_OUT: gpo_ff <= sh_ff;
                  `DCP_REG_GPIO_IN: ;
                  `DCP_REG_PORTSEL: psel_ff <= sh_ff;
                  `DCP_REG_LINKCFG: begin
                    if (wport[0]) lcfg_ff[0] <= sh_ff;
                    if (wport[1]) lcfg_ff[1] <= sh_ff;
                  end
                  `DCP_REG_RALIAS: begin
                    if (wport[0]) ralias_ff[0] <= sh_ff;
                    if (wport[1]) ralias_ff[1] <= sh_ff;
                  end
                  `DCP_REG_ALIAS0: alias0_ff <= sh_ff;
                  `DCP_REG_ALIAS1: alias1_ff <= sh_ff;
                  default: mem_ff[ptr_ff] <= sh_ff;
                endcase
                ptr_ff <= ptr_ff + 8'h01;
                SDA_OE <= 1'b1;
                st_ff <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              SDA_OE <= 1'b0;
              bit_ff <= 4'h0;
              if (!rw_ff) begin
                st_ff <= S_RX;
              end else if (fwd_ff) begin
                BC_REQ <= 1'b1;
                BC_CMD <= `DCP_CMD_READ;
                rdpend_ff <= 1'b1;
                SCL_OE <= 1'b1;
                st_ff <= S_STR;
              end else begin
                sh_ff <= rdata;
                SDA_OE <= ~rdata[7];
                ptr_ff <= ptr_ff + 8'h01;
                st_ff <= S_TX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_ff == `DCP_BYTE_BITS - 4'h1) begin
                SDA_OE <= 1'b0;
                st_ff <= S_TACK;
              end else begin
                SDA_OE <= ~sh_ff[6];
                sh_ff <= {sh_ff[6:0], 1'b0};
                bit_ff <= bit_ff + 4'h1;
              end
            end
          end
          S_TACK: begin
            if (scl_rise) begin
              hack_ff <= ~sda_s;
            end else if (scl_fall) begin
              bit_ff <= 4'h0;
              if (!hack_ff) begin
                st_ff <= S_IDLE;
              end else if (fwd_ff) begin
                BC_REQ <= 1'b1;
                BC_CMD <= `DCP_CMD_READ;
                rdpend_ff <= 1'b1;
                SCL_OE <= 1'b1;
                st_ff <= S_STR;
              end else begin
                sh_ff <= rdata;
                SDA_OE <= ~rdata[7];
                ptr_ff <= ptr_ff + 8'h01;
                st_ff <= S_TX;
              end
            end
          end
          S_STR: begin
            if (BC_DONE) begin
              SCL_OE <= 1'b0;
              if (rdpend_ff) begin
                rdpend_ff <= 1'b0;
                sh_ff <= BC_RDATA;
                SDA_OE <= ~BC_RDATA[7];
                bit_ff <= 4'h0;
                st_ff <= S_TX;
              end else if (BC_NACK) begin
                st_ff <= S_IDLE;
              end else begin
                SDA_OE <= 1'b1;
                st_ff <= S_ACK;
              end
            end
          end
          default: begin
            st_ff <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// >>> design/dcp_regs.vh
// register map, field positions and timing constants of the control port
`ifndef DCP_REGS_VH
`define DCP_REGS_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define DCP_REG_ID 8'h00
`define DCP_REG_GENCFG 8'h02
`define DCP_REG_GPIO_OUT 8'h10
`define DCP_REG_GPIO_IN 8'h11
`define DCP_REG_PORTSEL 8'h4c
`define DCP_REG_LINKCFG 8'h58
`define DCP_REG_RALIAS 8'h5c
`define DCP_REG_ALIAS0 8'hf8
`define DCP_REG_ALIAS1 8'hf9
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define DCP_PROXY_BIT 5
`define DCP_FWD_BIT 6
`define DCP_RATE_MSB 2
`define DCP_RATE_LSB 0
`define DCP_PSEL_WR0 0
`define DCP_PSEL_WR1 1
`define DCP_PSEL_RD 4
`define DCP_RATE_SLOW 3'h0
`define DCP_RATE_FAST 3'h1
`define DCP_CAPS 8'ha5
// ------------------------------------------------------------
// back channel commands
// ------------------------------------------------------------
`define DCP_CMD_START 2'h0
`define DCP_CMD_WRITE 2'h1
`define DCP_CMD_READ 2'h2
`define DCP_CMD_STOP 2'h3
// ------------------------------------------------------------
// strap addresses and timing
// ------------------------------------------------------------
`define DCP_ADDR0 7'h30
`define DCP_ADDR1 7'h32
`define DCP_ADDR2 7'h34
`define DCP_ADDR3 7'h36
`define DCP_ADDR4 7'h38
`define DCP_ADDR5 7'h3a
`define DCP_ADDR6 7'h3c
`define DCP_ADDR7 7'h3d
`define DCP_CLK_NS 10
`define DCP_STRAP_WAIT_NS 1000000
`define DCP_BYTE_BITS 4'h8
`endif

// >>> design/dcp_sync.v
// three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module dcp_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire CLK,
  input wire SRST,
  input wire CE,
  input wire [W-1:0] D,
  output reg [W-1:0] Q
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  // ------------------------------------------------------------
  // stages
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
      Q <= INIT;
    end else if (CE) begin
      s1_ff <= D;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        Q <= s3_ff;
      end
    end
  end
endmodule

// >>> design/dcp_strap.v
// address strap sampler: waits after chip enable, then latches the code once
`timescale 1ns/1ps
`include "dcp_regs.vh"
module dcp_strap #(
  parameter WAIT_CYCLES = `DCP_STRAP_WAIT_NS / `DCP_CLK_NS
) (
  input wire CLK,
  input wire SRST,
  input wire CE,
  input wire EN,
  input wire [2:0] CODE,
  output reg [6:0] ADDR,
  output reg DONE,
  output reg TAKE
);
  localparam integer LAST_I = WAIT_CYCLES - 1;
  localparam [16:0] LAST = LAST_I[16:0];
  reg [16:0] cnt_ff;
  // ------------------------------------------------------------
  // strap code to primary address
  // ------------------------------------------------------------
  function [6:0] strap_addr;
    input [2:0] c;
    begin
      case (c)
        3'h0: strap_addr = `DCP_ADDR0;
        3'h1: strap_addr = `DCP_ADDR1;
        3'h2: strap_addr = `DCP_ADDR2;
        3'h3: strap_addr = `DCP_ADDR3;
        3'h4: strap_addr = `DCP_ADDR4;
        3'h5: strap_addr = `DCP_ADDR5;
        3'h6: strap_addr = `DCP_ADDR6;
        default: strap_addr = `DCP_ADDR7;
      endcase
    end
  endfunction
  // ------------------------------------------------------------
  // wait and latch
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    if (SRST || !EN) begin
      cnt_ff <= 17'h0;
      DONE <= 1'b0;
      TAKE <= 1'b0;
      ADDR <= `DCP_ADDR0;
    end else if (CE) begin
      TAKE <= 1'b0;
      if (!DONE) begin
        if (cnt_ff == LAST) begin
          ADDR <= strap_addr(CODE);
          DONE <= 1'b1;
          TAKE <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 17'h1;
        end
      end
    end
  end
endmodule

// >>> bench/dcp_checker.sv
// concurrent checks on the ports of the control port
`timescale 1ns/1ps
`include "dcp_regs.vh"
module dcp_checker #(
  parameter STRAP_WAIT_CYCLES = 20
) (
  input wire CLK,
  input wire SRST,
  input wire CHIP_EN,
  input wire [1:0] SER_NEW,
  input wire SCL_O,
  input wire SCL_OE,
  input wire SDA_O,
  input wire SDA_OE,
  input wire BC_REQ,
  input wire [1:0] BC_CMD,
  input wire [7:0] BC_WDATA,
  input wire BC_PORT,
  input wire BC_RESTART,
  input wire BC_DONE,
  input wire BC_NACK,
  input wire [7:0] BC_CAPS,
  input wire PROXY_EN
);
  // ----------------------------------------
  // cycles since chip enable went high
  // ----------------------------------------
  reg [31:0] en_cnt_ff = 32'h0;
  wire [31:0] nxt_en_cnt = !CHIP_EN ? 32'h0 : (en_cnt_ff < STRAP_WAIT_CYCLES ? en_cnt_ff + 32'h1 : en_cnt_ff);
  always @(posedge CLK) begin
    en_cnt_ff <= nxt_en_cnt;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_issue;
    BC_REQ;
  endsequence
  sequence s_answer;
    BC_DONE && !BC_NACK && BC_CMD != `DCP_CMD_READ && SCL_OE;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_stretch_cause: assert property ($rose(SCL_OE) |-> s_issue)
    else $error("stretch began without a request");
  a_stretch_release: assert property (BC_DONE && SCL_OE |=> !SCL_OE)
    else $error("stretch kept after the answer");
  a_answer_ack: assert property (s_answer |=> SDA_OE)
    else $error("no ack after remote answer");
  a_req_pulse: assert property (s_issue |=> !BC_REQ)
    else $error("request longer than one cycle");
  a_cmd_hold: assert property (CHIP_EN && $past(CHIP_EN, 8) ##1 !BC_REQ |-> $stable(BC_CMD) && $stable(BC_WDATA))
    else $error("command changed without a request");
  a_caps_fixed: assert property (BC_CAPS == `DCP_CAPS)
    else $error("capability byte wrong");
  a_open_drain: assert property (!SCL_O && !SDA_O)
    else $error("bus line driven high");
  a_restart_new: assert property ($rose(BC_RESTART) |-> SER_NEW[BC_PORT])
    else $error("repeated start sent to an older serializer");
  a_reset_clear: assert property ($past(SRST) |-> !SCL_OE && !SDA_OE && !BC_REQ && !PROXY_EN)
    else $error("outputs active after reset");
  a_strap_quiet: assert property (en_cnt_ff < STRAP_WAIT_CYCLES |-> !SDA_OE)
    else $error("bus answered before the strap was taken");
endmodule
bind dcp_top dcp_checker #(.STRAP_WAIT_CYCLES(STRAP_WAIT_CYCLES)) i_dcp_checker (.CLK(CLK), .SRST(SRST),
  .CHIP_EN(CHIP_EN), .SER_NEW(SER_NEW), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
  .BC_REQ(BC_REQ), .BC_CMD(BC_CMD), .BC_WDATA(BC_WDATA), .BC_PORT(BC_PORT), .BC_RESTART(BC_RESTART),
  .BC_DONE(BC_DONE), .BC_NACK(BC_NACK), .BC_CAPS(BC_CAPS), .PROXY_EN(PROXY_EN));

// >>> bench/dcp_host.sv
// host bus controller model driving the serial clock and data lines
`timescale 1ns/1ps
module dcp_host (
  input wire clk,
  input wire scl_w,
  input wire sda_w,
  output reg scl_drv,
  output reg sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // one bit: low 5 cycles, high 3 cycles, waits out a stretch
  task bit_io(input b, output r);
    integer n;
    begin
      tick(2);
      sda_drv <= b;
      tick(3);
      scl_drv <= 1'b1;
      n = 0;
      @(negedge clk);
      while (!scl_w && n < 4000) begin
        n = n + 1;
        @(negedge clk);
      end
      tick(2);
      @(negedge clk);
      r = sda_w;
      tick(1);
      scl_drv <= 1'b0;
    end
  endtask
  task start_cond;
    begin
      tick(2);
      sda_drv <= 1'b1;
      tick(6);
      scl_drv <= 1'b1;
      tick(3);
      sda_drv <= 1'b0;
      tick(3);
      scl_drv <= 1'b0;
    end
  endtask
  task stop_cond;
    begin
      tick(2);
      sda_drv <= 1'b0;
      tick(3);
      scl_drv <= 1'b1;
      tick(3);
      sda_drv <= 1'b1;
      tick(4);
    end
  endtask
  task wr_byte(input [7:0] d, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
    end
  endtask
  task rd_byte(input last, output [7:0] d);
    integer i;
    reg r;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        bit_io(1'b1, r);
        d = {d[6:0], r};
      end
      bit_io(last, r);
    end
  endtask
endmodule

// >>> bench/tb_dcp_top.sv
// self-checking bench of the control port
`timescale 1ns/1ps
`include "dcp_regs.vh"
module tb_dcp_top;
  localparam [55:0] ADDRS = {7'h3d, 7'h3c, 7'h3a, 7'h38, 7'h36, 7'h34, 7'h32, 7'h30};
  reg clk, srst, chip_en, mode, bc_done, bc_nack;
  reg [2:0] strap;
  reg [1:0] ser_new;
  reg [3:0] gpio_in, dly;
  reg [7:0] bc_rdata, d, r;
  reg [6:0] dev;
  reg a;
  reg [10:0] e;
  reg [10:0] q_bc[$];
  integer bad_count, num_checks, seed, k;
  wire scl_oe, sda_oe, scl_o, sda_o, bc_req, bc_port, bc_restart, proxy_en, scl_drv, sda_drv;
  wire [1:0] bc_cmd;
  wire [2:0] rate0, rate1;
  wire [3:0] gpio_out;
  wire [7:0] bc_wdata, caps;
  wire scl_w = scl_drv & !(scl_oe & !scl_o);
  wire sda_w = sda_drv & !(sda_oe & !sda_o);
  dcp_top #(.STRAP_WAIT_CYCLES(20)) i_dcp_top (.CLK(clk), .SRST(srst), .CE(1'b1), .CHIP_EN(chip_en),
    .ADDRESS_STRAP(strap), .MODE_STRAP(mode), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .SER_NEW(ser_new), .BC_GPIO_IN(gpio_in), .BC_REQ(bc_req), .BC_CMD(bc_cmd),
    .BC_WDATA(bc_wdata), .BC_PORT(bc_port), .BC_RESTART(bc_restart), .BC_DONE(bc_done), .BC_NACK(bc_nack),
    .BC_RDATA(bc_rdata), .BC_RATE0(rate0), .BC_RATE1(rate1), .BC_GPIO_OUT(gpio_out), .BC_CAPS(caps),
    .PROXY_EN(proxy_en));
  dcp_host i_dcp_host (.clk(clk), .scl_w(scl_w), .sda_w(sda_w), .scl_drv(scl_drv), .sda_drv(sda_drv));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task chk(input [8*10-1:0] name, input [7:0] exp, input [7:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task wr_reg(input [6:0] dv, input [7:0] off, input [7:0] dat);
    begin
      i_dcp_host.start_cond;
      i_dcp_host.wr_byte({dv, 1'b0}, a);
      chk("ack_dev", 8'h1, {7'h0, a});
      i_dcp_host.wr_byte(off, a);
      i_dcp_host.wr_byte(dat, a);
      chk("ack_data", 8'h1, {7'h0, a});
      i_dcp_host.stop_cond;
      @(negedge clk);
    end
  endtask
  task rd_reg(input [6:0] dv, input [7:0] off);
    begin
      i_dcp_host.start_cond;
      i_dcp_host.wr_byte({dv, 1'b0}, a);
      chk("ack_rd", 8'h1, {7'h0, a});
      i_dcp_host.wr_byte(off, a);
      i_dcp_host.start_cond;
      i_dcp_host.wr_byte({dv, 1'b1}, a);
      i_dcp_host.rd_byte(1'b1, d);
      i_dcp_host.stop_cond;
      @(negedge clk);
    end
  endtask
  // ----------------------------------------
  // remote side answers after a random delay
  // ----------------------------------------
  always @(posedge clk) begin
    bc_done <= 1'b0;
    if (bc_req) dly <= 4'h3 + ($random(seed) & 4'h7);
    else if (dly != 4'h0) begin
      dly <= dly - 4'h1;
      bc_done <= (dly == 4'h1);
    end
  end
  always @(negedge clk) begin
    if (bc_req) begin
      if (q_bc.size() == 0) chk("bc_extra", 8'h0, 8'h1);
      else begin
        e = q_bc.pop_front();
        chk("bc_cmd", {5'h0, e[10:8]}, {5'h0, bc_port, bc_cmd});
        if (e[9:8] < 2'h2) chk("bc_wdata", e[7:0], bc_wdata);
      end
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hccb6;
    bad_count = 0;
    num_checks = 0;
    srst = 1'b1;
    chip_en = 1'b0;
    strap = 3'h0;
    mode = 1'b0;
    ser_new = 2'b01;
    gpio_in = $random(seed);
    bc_rdata = $random(seed);
    bc_done = 1'b0;
    bc_nack = 1'b0;
    dly = 4'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("caps", `DCP_CAPS, caps);
    chk("proxy_rst", 8'h0, {7'h0, proxy_en});
    for (k = 0; k < 8; k = k + 1) begin
      @(posedge clk);
      chip_en <= 1'b0;
      strap <= k[2:0];
      mode <= k[0];
      repeat (10) @(posedge clk);
      chip_en <= 1'b1;
      repeat (40) @(posedge clk);
      strap <= ~k[2:0];
      dev = ADDRS[k*7 +: 7];
      rd_reg(dev, `DCP_REG_ID);
      chk("id", {1'b0, dev}, {1'b0, d[6:0]});
      chk("rate_dflt", {5'h0, k[0] ? `DCP_RATE_FAST : `DCP_RATE_SLOW}, {5'h0, rate1});
    end
    wr_reg(dev, `DCP_REG_GENCFG, 8'h20);
    chk("proxy_on", 8'h1, {7'h0, proxy_en});
    wr_reg(dev, `DCP_REG_GENCFG, 8'h00);
    chk("proxy_off", 8'h0, {7'h0, proxy_en});
    r = $random(seed);
    wr_reg(dev, `DCP_REG_GPIO_OUT, r);
    chk("gpio_out", {4'h0, r[3:0]}, {4'h0, gpio_out});
    rd_reg(dev, `DCP_REG_GPIO_IN);
    chk("gpio_in", {4'h0, gpio_in}, {4'h0, d[3:0]});
    wr_reg(dev, `DCP_REG_ALIAS0, 8'h50);
    wr_reg(dev, `DCP_REG_ALIAS1, 8'h52);
    rd_reg(7'h50, `DCP_REG_ID);
    chk("id_alias", {1'b0, dev}, {1'b0, d[6:0]});
    wr_reg(7'h52, `DCP_REG_LINKCFG, 8'h00);
    chk("rate1", 8'h0, {5'h0, rate1});
    wr_reg(7'h50, `DCP_REG_LINKCFG, 8'h00);
    chk("rate0", 8'h0, {5'h0, rate0});
    // link assumed locked, port 0 paged before remote access
    wr_reg(dev, `DCP_REG_PORTSEL, 8'h01);
    wr_reg(dev, `DCP_REG_RALIAS, 8'h44);
    wr_reg(dev, `DCP_REG_LINKCFG, 8'h41);
    chk("rate0_fast", {5'h0, `DCP_RATE_FAST}, {5'h0, rate0});
    r = $random(seed);
    q_bc.push_back({1'b0, `DCP_CMD_START, 8'h88});
    q_bc.push_back({1'b0, `DCP_CMD_WRITE, r});
    q_bc.push_back({1'b0, `DCP_CMD_STOP, 8'h00});
    q_bc.push_back({1'b0, `DCP_CMD_START, 8'h88});
    q_bc.push_back({1'b0, `DCP_CMD_START, 8'h89});
    q_bc.push_back({1'b0, `DCP_CMD_READ, 8'h00});
    q_bc.push_back({1'b0, `DCP_CMD_STOP, 8'h00});
    i_dcp_host.start_cond;
    i_dcp_host.wr_byte(8'h88, a);
    i_dcp_host.wr_byte(r, a);
    chk("rem_ack", 8'h1, {7'h0, a});
    i_dcp_host.stop_cond;
    i_dcp_host.start_cond;
    i_dcp_host.wr_byte(8'h88, a);
    i_dcp_host.start_cond;
    i_dcp_host.wr_byte(8'h89, a);
    @(negedge clk);
    chk("restart", 8'h1, {7'h0, bc_restart});
    i_dcp_host.rd_byte(1'b1, d);
    i_dcp_host.stop_cond;
    chk("rem_data", bc_rdata, d);
    // remote side refuses the address: no ack, stop still relayed
    bc_nack <= 1'b1;
    q_bc.push_back({1'b0, `DCP_CMD_START, 8'h88});
    q_bc.push_back({1'b0, `DCP_CMD_STOP, 8'h00});
    i_dcp_host.start_cond;
    i_dcp_host.wr_byte(8'h88, a);
    i_dcp_host.stop_cond;
    chk("rem_nack", 8'h0, {7'h0, a});
    bc_nack <= 1'b0;
    wr_reg(dev, `DCP_REG_LINKCFG, 8'h01);
    i_dcp_host.start_cond;
    i_dcp_host.wr_byte(8'h88, a);
    i_dcp_host.stop_cond;
    chk("no_fwd", 8'h0, {7'h0, a});
    repeat (20) @(posedge clk);
    chk("bc_left", 8'h0, q_bc.size());
    give_verdict;
  end
endmodule
